// >>> hdl/uer_mck_tick.sv
`timescale 1ns/1ps
module uer_mck_tick (
	input wire logic clk_in, // System clock
	input wire logic resetn_in, // Async reset, active low
	output logic tick_out // One-cycle operation clock enable
);
	logic [7:0] cnt_ff;
	logic tick_ff;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else if (cnt_ff == uer_pkg::MCK_DIV - 8'h01) begin
			cnt_ff <= 8'h00;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	assign tick_out = tick_ff;
endmodule : uer_mck_tick

// >>> hdl/uer_pin_sync.sv
`timescale 1ns/1ps
module uer_pin_sync (
	input wire logic clk_in, // System clock
	input wire logic resetn_in, // Async reset, active low
	input wire logic pin_in, // Asynchronous pin
	output logic level_out // Filtered level, idles high
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A change is taken only once the last two stages agree
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_ff <= 1'b1;
		end else if (s2_ff == s3_ff) begin
			level_ff <= s3_ff;
		end
	end

	assign level_out = level_ff;
endmodule : uer_pin_sync

// >>> hdl/uer_rx_channel.sv
`timescale 1ns/1ps
module uer_rx_channel (
	input wire logic clk_in, // System clock, 100 MHz
	input wire logic resetn_in, // Async reset, active low
	input wire logic [5:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [31:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Write byte lanes
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Slave stall
	input wire logic rxd_in, // Serial receive pin
	output logic irq_out, // Level interrupt
	output logic channel_enabled_out // Channel enable status
);
	logic tick;
	logic rxd_s;
	logic waitreq_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic done_rd;
	logic done_wr;
	logic [6:0] div_ff;
	logic [1:0] mode_ff;
	logic en_ff;
	logic [uer_pkg::DATA_BITS-1:0] buf_ff;
	logic bff_ff;
	uer_pkg::uer_err_t err_ff;
	uer_pkg::uer_err_t err_set;
	uer_pkg::uer_err_t err_clr;
	logic [1:0] int_stat_ff;
	logic [1:0] int_mask_ff;
	logic [1:0] int_set;
	logic irq_ff;
	uer_pkg::uer_rx_state_t state_ff;
	logic [8:0] cnt_ff;
	logic [2:0] bitn_ff;
	logic [7:0] shift_ff;
	logic par_acc_ff;
	logic [8:0] half_cnt;
	logic [8:0] full_cnt;
	logic rx_done;
	logic stop_wr;
	logic start_wr;
	logic clr_wr;
	logic data_rd;

	function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
		hit = (addr == off);
	endfunction : hit

	uer_mck_tick u_tick (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.tick_out(tick)
	);

	uer_pin_sync u_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.pin_in(rxd_in),
		.level_out(rxd_s)
	);

	// Bus: request seen with waitrequest high, answered one cycle later
	assign done_rd = avs_read_in && !waitreq_ff;
	assign done_wr = avs_write_in && !waitreq_ff;
	assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign wbits = avs_writedata_in & wmask;
	assign data_rd = done_rd && hit(avs_address_in, uer_pkg::OFF_DATA);
	assign clr_wr = done_wr && hit(avs_address_in, uer_pkg::OFF_CLEAR);
	assign stop_wr = done_wr && hit(avs_address_in, uer_pkg::OFF_STOP)
		&& wbits[uer_pkg::CH_BIT];
	assign start_wr = done_wr && hit(avs_address_in, uer_pkg::OFF_START)
		&& wbits[uer_pkg::CH_BIT];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			waitreq_ff <= 1'b1;
		end else begin
			waitreq_ff <= !((avs_read_in || avs_write_in) && waitreq_ff);
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (avs_address_in)
			uer_pkg::OFF_DATA: begin
				nxt_rdata[uer_pkg::DIV_MSB:uer_pkg::DIV_LSB] = div_ff;
				nxt_rdata[7:0] = buf_ff;
			end
			uer_pkg::OFF_STATUS: begin
				nxt_rdata[uer_pkg::ST_BFF] = bff_ff;
				nxt_rdata[uer_pkg::ST_FRM] = err_ff.framing;
				nxt_rdata[uer_pkg::ST_PAR] = err_ff.parity;
				nxt_rdata[uer_pkg::ST_OVR] = err_ff.overrun;
			end
			uer_pkg::OFF_ENABLE: nxt_rdata[uer_pkg::CH_BIT] = en_ff;
			uer_pkg::OFF_MODE: nxt_rdata[1:0] = mode_ff;
			uer_pkg::OFF_INT_STAT: nxt_rdata[1:0] = int_stat_ff;
			uer_pkg::OFF_INT_MASK: nxt_rdata[1:0] = int_mask_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is latched while stalled so it stands at the answering edge
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read_in && waitreq_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Software configuration
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_ff <= uer_pkg::DIV_RST;
			mode_ff <= uer_pkg::MODE_RST;
			int_mask_ff <= uer_pkg::INT_MASK_RST;
		end else if (done_wr) begin
			if (hit(avs_address_in, uer_pkg::OFF_DATA) && avs_byteenable_in[1]) begin
				div_ff <= avs_writedata_in[uer_pkg::DIV_MSB:uer_pkg::DIV_LSB];
			end
			if (hit(avs_address_in, uer_pkg::OFF_MODE) && avs_byteenable_in[0]) begin
				mode_ff <= avs_writedata_in[1:0];
			end
			if (hit(avs_address_in, uer_pkg::OFF_INT_MASK) && avs_byteenable_in[0]) begin
				int_mask_ff <= avs_writedata_in[1:0];
			end
		end
	end

	// Channel start and stop triggers; stop wins if both arrive together
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			en_ff <= 1'b0;
		end else if (stop_wr) begin
			en_ff <= 1'b0;
		end else if (start_wr) begin
			en_ff <= 1'b1;
		end
	end

	// Half a bit is k ticks, a whole bit 2k ticks, k = divider + 1
	assign half_cnt = {2'b00, div_ff};
	assign full_cnt = {div_ff + 7'h01 == 7'h00, div_ff + 7'h01, 1'b0} - 9'h001;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= uer_pkg::RX_IDLE;
			cnt_ff <= 9'h000;
			bitn_ff <= 3'h0;
			shift_ff <= 8'h00;
			par_acc_ff <= 1'b0;
		end else if (!en_ff || stop_wr) begin
			state_ff <= uer_pkg::RX_IDLE;
		end else if (tick) begin
			if (state_ff != uer_pkg::RX_IDLE && cnt_ff != 9'h000) begin
				cnt_ff <= cnt_ff - 9'h001;
			end else begin
				unique case (state_ff)
					uer_pkg::RX_IDLE: begin
						if (!rxd_s) begin
							state_ff <= uer_pkg::RX_START;
							cnt_ff <= half_cnt;
						end
					end
					uer_pkg::RX_START: begin
						// A start bit gone high by mid-bit was a glitch
						if (rxd_s) begin
							state_ff <= uer_pkg::RX_IDLE;
						end else begin
							state_ff <= uer_pkg::RX_DATA;
							cnt_ff <= full_cnt;
							bitn_ff <= 3'h0;
							par_acc_ff <= mode_ff[uer_pkg::MODE_PAR_ODD];
						end
					end
					uer_pkg::RX_DATA: begin
						shift_ff <= {rxd_s, shift_ff[7:1]};
						par_acc_ff <= par_acc_ff ^ rxd_s;
						cnt_ff <= full_cnt;
						bitn_ff <= bitn_ff + 3'h1;
						if (bitn_ff == 3'h7) begin
							state_ff <= mode_ff[uer_pkg::MODE_PAR_EN] ?
								uer_pkg::RX_PAR : uer_pkg::RX_STOP;
						end
					end
					uer_pkg::RX_PAR: begin
						par_acc_ff <= par_acc_ff ^ rxd_s;
						cnt_ff <= full_cnt;
						state_ff <= uer_pkg::RX_STOP;
					end
					uer_pkg::RX_STOP: begin
						state_ff <= uer_pkg::RX_IDLE;
					end
				endcase
			end
		end
	end

	// Stop bit latched at its own mid-point ends the frame
	assign rx_done = en_ff && !stop_wr && tick && state_ff == uer_pkg::RX_STOP
		&& cnt_ff == 9'h000;

	always_comb begin
		err_set.framing = rx_done && !rxd_s;
		err_set.parity = rx_done && mode_ff[uer_pkg::MODE_PAR_EN] && par_acc_ff;
		err_set.overrun = rx_done && bff_ff && !data_rd;
		err_clr.framing = clr_wr && wbits[uer_pkg::ST_FRM];
		err_clr.parity = clr_wr && wbits[uer_pkg::ST_PAR];
		err_clr.overrun = clr_wr && wbits[uer_pkg::ST_OVR];
	end

	// Overrun keeps the newest character; the older one is lost
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			buf_ff <= 8'h00;
			bff_ff <= 1'b0;
		end else if (rx_done) begin
			buf_ff <= shift_ff;
			bff_ff <= 1'b1;
		end else if (data_rd) begin
			bff_ff <= 1'b0;
		end
	end

	// Sticky flags, a new error wins over a simultaneous clear
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			err_ff <= '0;
		end else begin
			err_ff <= (err_ff & ~err_clr) | err_set;
		end
	end

	assign int_set[uer_pkg::INT_RX] = rx_done;
	assign int_set[uer_pkg::INT_ERR] = |err_set;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			int_stat_ff <= 2'h0;
			irq_ff <= 1'b0;
		end else begin
			if (done_wr && hit(avs_address_in, uer_pkg::OFF_INT_STAT)) begin
				int_stat_ff <= (int_stat_ff & ~wbits[1:0]) | int_set;
			end else begin
				int_stat_ff <= int_stat_ff | int_set;
			end
			irq_ff <= |(int_stat_ff & int_mask_ff);
		end
	end

	assign avs_readdata_out = rdata_ff;
	assign avs_waitrequest_out = waitreq_ff;
	assign irq_out = irq_ff;
	assign channel_enabled_out = en_ff;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	chk_bus_answer: assert property (
		(avs_read_in || avs_write_in) && waitreq_ff |=> !waitreq_ff ##1 waitreq_ff)
		else $error("bus request not answered in one cycle");

	chk_bit_timing: assert property (
		tick && en_ff && !stop_wr && state_ff == uer_pkg::RX_START
		&& cnt_ff == 9'h000 && !rxd_s
		|=> state_ff == uer_pkg::RX_DATA && cnt_ff == 9'(2 * (div_ff + 1) - 1))
		else $error("bit period not taken from divider field");

	chk_stop_accept: assert property (
		rx_done |=> bff_ff && buf_ff == $past(shift_ff)
		&& (err_ff.framing == (($past(err_ff.framing) && !$past(err_clr.framing))
		|| !$past(rxd_s))))
		else $error("frame not accepted at stop latch");

	chk_read_clr_bff: assert property (
		data_rd && !rx_done |=> !bff_ff)
		else $error("data read did not clear buffer full");

	chk_clear_flags: assert property (
		clr_wr && wbits[uer_pkg::ST_FRM] && !err_set.framing |=> !err_ff.framing)
		else $error("framing flag not cleared by trigger");

	chk_stop_halt: assert property (
		stop_wr |=> !en_ff && state_ff == uer_pkg::RX_IDLE && !channel_enabled_out)
		else $error("stop trigger did not halt channel");

	chk_start_run: assert property (
		start_wr && !stop_wr |=> en_ff ##0 channel_enabled_out)
		else $error("start trigger did not enable channel");

	chk_flags_sticky: assert property (
		err_ff.parity && !(clr_wr && wbits[uer_pkg::ST_PAR])
		|=> err_ff.parity)
		else $error("parity flag dropped without clear");

endmodule : uer_rx_channel

// >>> include/uer_pkg.sv
package uer_pkg;

	// Register byte offsets, one aligned 32-bit word each
	localparam logic [5:0] OFF_DATA = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_CLEAR = 6'h08;
	localparam logic [5:0] OFF_START = 6'h0c;
	localparam logic [5:0] OFF_STOP = 6'h10;
	localparam logic [5:0] OFF_ENABLE = 6'h14;
	localparam logic [5:0] OFF_MODE = 6'h18;
	localparam logic [5:0] OFF_INT_STAT = 6'h1c;
	localparam logic [5:0] OFF_INT_MASK = 6'h20;

	// channel_data_reg fields
	localparam int DIV_MSB = 15;
	localparam int DIV_LSB = 9;
	localparam int DATA_BITS = 8;

	// channel_status_reg / flag_clear_trigger_reg fields
	localparam int ST_OVR = 0;
	localparam int ST_PAR = 1;
	localparam int ST_FRM = 2;
	localparam int ST_BFF = 5;

	// Mode register fields
	localparam int MODE_PAR_EN = 0;
	localparam int MODE_PAR_ODD = 1;

	// Interrupt status / mask fields
	localparam int INT_RX = 0;
	localparam int INT_ERR = 1;

	// Start, stop and enable-status bit of this channel
	localparam int CH_BIT = 0;

	// Reset values
	localparam logic [6:0] DIV_RST = 7'h40;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] INT_MASK_RST = 2'h0;

	// Operation clock: system clock divided down to an enable pulse
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MCK_HZ = 50_000_000;
	localparam logic [7:0] MCK_DIV = 8'(CLK_HZ / MCK_HZ);

	typedef struct packed {
		logic framing;
		logic parity;
		logic overrun;
	} uer_err_t;

	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_PAR = 5'b01000,
		RX_STOP = 5'b10000
	} uer_rx_state_t;

endpackage : uer_pkg

// >>> verif/test_uer_rx_channel.sv
`timescale 1ns/1ps
module test_uer_rx_channel;
	localparam logic [31:0] DIV_W = 32'h0000_0600;
	localparam int BIT_CYC = 16;
	logic clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out, rxd_in, irq_out;
	logic channel_enabled_out;
	logic [5:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rnd;
	logic [63:0] exp_q[$];
	logic [63:0] e;
	logic [7:0] b;
	int fail_count, check_count;

	uer_rx_channel i_uer_rx_channel (.clk_in(clk_in), .resetn_in(resetn_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in), .irq_out(irq_out),
		.channel_enabled_out(channel_enabled_out));
	uer_tx_model i_uer_tx_model (.clk_in(clk_in), .rxd_out(rxd_in));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic close_out();
		begin
			$display("Comparisons %0d, mismatches %0d", check_count, fail_count);
			if (fail_count == 0 && check_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask : close_out

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		begin
			check_count++;
			if (got !== exp) begin
				fail_count++;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask : cmp

	task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		begin
			n = 0;
			avs_address_in <= a;
			avs_writedata_in <= d;
			avs_read_in <= !wr;
			avs_write_in <= wr;
			do begin
				@(posedge clk_in);
				n++;
			end while (avs_waitrequest_out !== 1'b0 && n < 50);
			avs_read_in <= 1'b0;
			avs_write_in <= 1'b0;
			if (avs_waitrequest_out !== 1'b0) begin
				fail_count++;
				close_out();
			end else begin
				@(posedge clk_in);
			end
		end
	endtask : access

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		access(1'b1, a, d);
	endtask : wr

	// Expected value and compare mask go on the queue before the read is issued
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		begin
			exp_q.push_back({32'hffff_ffff, exp});
			access(1'b0, a, 32'h0);
		end
	endtask : rd

	always @(posedge clk_in) begin
		if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
			e = exp_q.pop_front();
			cmp(avs_readdata_out & e[63:32], e[31:0]);
		end
	end

	task automatic frame(input logic [1:0] mode, input logic bp, input logic bs,
		input logic [31:0] st);
		begin
			wr(6'h18, {30'h0, mode});
			rnd = lfsr(rnd);
			b = rnd[7:0];
			i_uer_tx_model.send(b, mode, bp, bs, BIT_CYC);
			cmp(irq_out, 32'h1);
			wr(6'h20, 32'h0);
			@(posedge clk_in);
			cmp(irq_out, 32'h0);
			wr(6'h20, 32'h3);
			@(posedge clk_in);
			cmp(irq_out, 32'h1);
			rd(6'h04, st | 32'h20);
			rd(6'h00, DIV_W | b);
			rd(6'h04, st);
			wr(6'h08, st);
			rd(6'h04, 32'h0);
			wr(6'h1c, 32'h3);
			@(posedge clk_in);
			cmp(irq_out, 32'h0);
		end
	endtask : frame

	initial begin
		resetn_in = 1'b0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_address_in = 6'h00;
		avs_writedata_in = 32'h0;
		rnd = 32'h6ab8;
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		rd(6'h00, 32'h0000_8000);
		rd(6'h04, 32'h0);
		rd(6'h14, 32'h0);
		rd(6'h24, 32'h0);
		wr(6'h00, DIV_W);
		wr(6'h20, 32'h3);
		wr(6'h0c, 32'h1);
		rd(6'h14, 32'h1);
		cmp(channel_enabled_out, 32'h1);
		frame(2'h0, 1'b0, 1'b0, 32'h0);
		for (int m = 1; m < 4; m += 2) begin
			frame(m[1:0], 1'b0, 1'b0, 32'h0);
			frame(m[1:0], 1'b1, 1'b0, 32'h2);
		end
		// Two frames with no read between: the second overruns and is kept
		// Mode is still odd parity from the loop above, so this frame carries it too
		i_uer_tx_model.send(8'h5a, 2'h3, 1'b0, 1'b0, BIT_CYC);
		frame(2'h0, 1'b0, 1'b0, 32'h1);
		frame(2'h0, 1'b0, 1'b1, 32'h4);
		wr(6'h10, 32'h1);
		rd(6'h14, 32'h0);
		cmp(channel_enabled_out, 32'h0);
		i_uer_tx_model.send(8'h33, 2'h0, 1'b0, 1'b0, BIT_CYC);
		rd(6'h04, 32'h0);
		wr(6'h0c, 32'h1);
		frame(2'h0, 1'b0, 1'b0, 32'h0);
		close_out();
	end
endmodule : test_uer_rx_channel

// >>> verif/uer_tx_model.sv
`timescale 1ns/1ps
module uer_tx_model (
	input wire logic clk_in, // System clock
	output logic rxd_out // Serial line, idles high
);
	initial rxd_out = 1'b1;
	// Sends at exactly the receiver's bit time, so it stays inside the receive window
	task automatic send(input logic [7:0] d, input logic [1:0] mode, input logic bad_par,
		input logic bad_stop, input int bit_cyc);
		logic [10:0] f;
		int n;
		begin
			f = {1'b1, ^d ^ mode[1] ^ bad_par, d, 1'b0};
			n = mode[0] ? 11 : 10;
			if (!mode[0])
				f[9] = 1'b1;
			if (bad_stop)
				f[n - 1] = 1'b0;
			// A bad stop bit is cut short so the line is high again before a false start
			// could be confirmed
			for (int i = 0; i < n + 2; i++) begin
				rxd_out <= (i < n) ? f[i] : 1'b1;
				repeat ((bad_stop && i == n - 1) ? bit_cyc * 3 / 4 : bit_cyc) @(posedge clk_in);
			end
		end
	endtask : send
endmodule : uer_tx_model
